// file: bench/dams_meter.sv
`default_nettype none
module dams_meter #(
  parameter int unsigned DAC_W = 12
) (
  input  wire logic             i_clk,
  input  wire logic [DAC_W-1:0] i_code,
  output logic      [15:0]      o_mv
);
  timeunit 1ns;
  timeprecision 1ps;
  // integer millivolts; full code reads 5 V, so mid code rounds down to the centre
  always_ff @(posedge i_clk) begin
    o_mv <= 16'((32'(i_code) * 5000) / ((1 << DAC_W) - 1));
  end
endmodule // dams_meter
`default_nettype wire

// file: bench/dams_top_bench.sv
`default_nettype none
module dams_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   i_clk;
  logic                   i_rstn;
  logic                   avs_read;
  logic                   avs_write;
  logic                   avs_wait;
  logic [4:0]             avs_address;
  logic [31:0]            avs_wdata;
  logic [31:0]            avs_rdata;
  logic [31:0]            rdv;
  logic [31:0]            link1;
  logic [31:0]            link2;
  logic [31:0]            in_func;
  logic [31:0]            out_func;
  logic [11:0]            out1;
  logic [11:0]            out2;
  logic [15:0]            mv1;
  dams_pkg::dams_preset_s presets;
  int                     n_errors;
  int                     comparisons;
  int                     lv[4] = '{1100, 2000, -5000, 900};

  dams_top #(.DAC_W(12), .FUNC_N(32)) u_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait), .i_presets(presets),
    .i_first_link_value(link1), .i_second_link_value(link2), .i_in_func_state(in_func),
    .i_out_func_state(out_func), .o_first_analog_out(out1), .o_second_analog_out(out2));
  dams_meter #(.DAC_W(12)) u_meter (.i_clk(i_clk), .i_code(out1), .o_mv(mv1));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(logic wrn, logic [4:0] a, logic [31:0] d);
    int n;
    @(posedge i_clk);
    avs_address <= a;
    avs_wdata <= d;
    avs_write <= wrn;
    avs_read <= !wrn;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (avs_wait !== 1'b0 && n < 50);
    rdv = avs_rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) check("waitrequest", 32'(avs_wait), 32'h0);
  endtask

  task automatic rdc(string name, logic [4:0] a, logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, rdv, exp);
  endtask

  task automatic settle();
    // a channel reloads every 28 cycles and stores 13 later, so a change just missed needs 41
    repeat (64) @(posedge i_clk);
  endtask

  function automatic logic [31:0] ec(longint v, longint o, longint r);
    longint d;
    d = v - o;
    if (d >= r) return 32'h0000_0fff;
    if (-d >= r) return 32'h0;
    if (d >= 0) return 32'(2048 + d * 2047 / r);
    return 32'(2048 - (-d) * 2048 / r);
  endfunction

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end

  initial begin
    i_rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_wdata = 32'h0;
    presets = '0;
    link1 = 32'h0;
    link2 = 32'h0;
    in_func = 32'h0;
    out_func = 32'h0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    rdc("first_sel", 5'h00, 32'h0);
    rdc("first_rng", 5'h04, 32'h0000_2710);
    rdc("first_ofs", 5'h08, 32'h0);
    rdc("second_sel", 5'h0c, 32'h0);
    rdc("second_rng", 5'h10, 32'h0000_2710);
    rdc("second_ofs", 5'h14, 32'h0);
    settle();
    check("first_mid", 32'(out1), 32'h0000_0800);
    check("meter_mv", 32'(mv1), 32'd2500);
    @(posedge i_clk);
    for (int k = 0; k < 9; k++) presets[(8 - k) * 32 +: 32] <= 32'((k - 4) * 2000);
    for (int k = 0; k < 9; k++) begin
      bus(1'b1, 5'h00, 32'(k << 4));
      bus(1'b1, 5'h0c, 32'((8 - k) << 4));
      settle();
      check("first_preset", 32'(out1), ec((k - 4) * 2000, 0, 10000));
      check("second_preset", 32'(out2), ec((4 - k) * 2000, 0, 10000));
    end
    // link source under a narrow window around 1.000
    bus(1'b1, 5'h00, 32'h0000_0001);
    bus(1'b1, 5'h04, 32'h0000_00c8);
    bus(1'b1, 5'h08, 32'h0000_03e8);
    for (int i = 0; i < 4; i++) begin
      link1 <= 32'(lv[i]);
      settle();
      check("first_link", 32'(out1), ec(lv[i], 1000, 200));
    end
    bus(1'b1, 5'h0c, 32'h0000_0001);
    link2 <= -32'sd3000;
    settle();
    check("second_link", 32'(out2), ec(-3000, 0, 10000));
    // input function 4 on the first output, output function 3 on the second
    bus(1'b1, 5'h00, 32'h0000_0802);
    rdc("func_rng", 5'h04, 32'h0000_03e8);
    rdc("func_ofs", 5'h08, 32'h0);
    in_func <= 32'h0000_0010;
    settle();
    check("in_func_on", 32'(out1), 32'h0000_0fff);
    in_func <= 32'hffff_ffef;
    settle();
    check("in_func_off", 32'(out1), 32'h0000_0800);
    bus(1'b1, 5'h0c, 32'h0000_0702);
    out_func <= 32'h0000_0008;
    settle();
    check("out_func_on", 32'(out2), 32'h0000_0fff);
    rdc("status", 5'h18, 32'h0fff_0800);
    rdc("unmapped", 5'h1c, 32'h0);
    print_verdict();
  end
endmodule // dams_top_bench
`default_nettype wire

// file: common/dams_consts.svh
`ifndef DAMS_CONSTS_SVH
`define DAMS_CONSTS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DAMS_OFF_FIRST_SEL   5'h00
`define DAMS_OFF_FIRST_RNG   5'h04
`define DAMS_OFF_FIRST_OFS   5'h08
`define DAMS_OFF_SECOND_SEL  5'h0c
`define DAMS_OFF_SECOND_RNG  5'h10
`define DAMS_OFF_SECOND_OFS  5'h14
`define DAMS_OFF_STATUS      5'h18
// ----------------------------------------------------------------
// reset values, function range and function level, in thousandths of the source unit
// ----------------------------------------------------------------
`define DAMS_SEL_RST         32'h0000_0000
`define DAMS_RANGE_RST       32'h0000_2710
`define DAMS_OFFSET_RST      32'h0000_0000
`define DAMS_FUNC_RANGE      32'h0000_03e8
`define DAMS_FUNC_ON         32'h0000_03e8
// ----------------------------------------------------------------
// source select and status fields
// ----------------------------------------------------------------
`define DAMS_KIND_MSB        1
`define DAMS_KIND_LSB        0
`define DAMS_PCODE_MSB       7
`define DAMS_PCODE_LSB       4
`define DAMS_FDIR_BIT        8
`define DAMS_FIDX_MSB        13
`define DAMS_FIDX_LSB        9
`define DAMS_PCODE_LAST      4'h8
`define DAMS_STAT_HI_LSB     16
`endif

// file: common/dams_pkg.sv
`default_nettype none
package dams_pkg;
  typedef enum logic [1:0] {
    DAMS_KIND_PRESET = 2'h0,
    DAMS_KIND_LINK   = 2'h1,
    DAMS_KIND_FUNC   = 2'h2
  } dams_kind_e;

  typedef enum logic [2:0] {
    DAMS_ST_IDLE  = 3'h4,
    DAMS_ST_LOAD  = 3'h0,
    DAMS_ST_PREP  = 3'h1,
    DAMS_ST_DIV   = 3'h3,
    DAMS_ST_STORE = 3'h2
  } dams_state_e;

  // all quantities signed, in thousandths of their own unit
  typedef struct packed {
    logic signed [31:0] act_vel;
    logic signed [31:0] cmd_vel;
    logic signed [31:0] vel_err;
    logic signed [31:0] trq_cmd;
    logic signed [31:0] u_cur;
    logic signed [31:0] trans_pos;
    logic signed [31:0] pos_err_narrow;
    logic signed [31:0] pos_err_wide;
    logic signed [31:0] thermal;
  } dams_preset_s;
endpackage
`default_nettype wire

// file: hw/dams_top.sv
`include "dams_consts.svh"
`default_nettype none
module dams_top #(
  parameter int unsigned DAC_W  = 12,
  parameter int unsigned FUNC_N = 32
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  input  wire logic [4:0]           i_avs_address,
  input  wire logic                 i_avs_read,
  input  wire logic                 i_avs_write,
  input  wire logic [31:0]          i_avs_writedata,
  input  wire logic [3:0]           i_avs_byteenable,
  output logic      [31:0]          o_avs_readdata,
  output logic                      o_avs_waitrequest,
  input  wire dams_pkg::dams_preset_s i_presets,
  input  wire logic [31:0]          i_first_link_value,
  input  wire logic [31:0]          i_second_link_value,
  input  wire logic [FUNC_N-1:0]    i_in_func_state,
  input  wire logic [FUNC_N-1:0]    i_out_func_state,
  output logic      [DAC_W-1:0]     o_first_analog_out,
  output logic      [DAC_W-1:0]     o_second_analog_out
);
  localparam int unsigned NW = 33 + DAC_W;
  localparam logic [DAC_W-1:0] MID    = {1'b1, {(DAC_W-1){1'b0}}};
  localparam logic [DAC_W-1:0] MAXC   = '1;
  localparam logic [DAC_W-1:0] HALF_P = MAXC - MID;
  localparam logic [DAC_W-1:0] HALF_N = MID;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] pick_preset(input dams_pkg::dams_preset_s p, input logic [3:0] code);
    case (code)
      4'h0:    pick_preset = p.act_vel;
      4'h1:    pick_preset = p.cmd_vel;
      4'h2:    pick_preset = p.vel_err;
      4'h3:    pick_preset = p.trq_cmd;
      4'h4:    pick_preset = p.u_cur;
      4'h5:    pick_preset = p.trans_pos;
      4'h6:    pick_preset = p.pos_err_narrow;
      4'h7:    pick_preset = p.pos_err_wide;
      4'h8:    pick_preset = p.thermal;
      default: pick_preset = 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic        wait_r;
  logic [31:0] rdata_r;
  logic [31:0] first_source_select_r;
  logic [31:0] first_scale_range_r;
  logic [31:0] first_center_offset_r;
  logic [31:0] second_source_select_r;
  logic [31:0] second_scale_range_r;
  logic [31:0] second_center_offset_r;
  logic [DAC_W-1:0] first_out_r;
  logic [DAC_W-1:0] second_out_r;

  // answer one cycle after the request is seen; a write lands on the edge after the one that ends the wait
  wire        req      = i_avs_read | i_avs_write;
  wire        commit   = i_avs_write & ~wait_r;
  wire        wait_nxt = ~(req & wait_r);
  wire        wr_fsel  = commit && (i_avs_address == `DAMS_OFF_FIRST_SEL);
  wire        wr_frng  = commit && (i_avs_address == `DAMS_OFF_FIRST_RNG);
  wire        wr_fofs  = commit && (i_avs_address == `DAMS_OFF_FIRST_OFS);
  wire        wr_ssel  = commit && (i_avs_address == `DAMS_OFF_SECOND_SEL);
  wire        wr_srng  = commit && (i_avs_address == `DAMS_OFF_SECOND_RNG);
  wire        wr_sofs  = commit && (i_avs_address == `DAMS_OFF_SECOND_OFS);
  wire [31:0] fsel_new = be_merge(first_source_select_r, i_avs_writedata, i_avs_byteenable);
  wire [31:0] ssel_new = be_merge(second_source_select_r, i_avs_writedata, i_avs_byteenable);
  wire        f_to_func = wr_fsel && (fsel_new[`DAMS_KIND_MSB:`DAMS_KIND_LSB] == dams_pkg::DAMS_KIND_FUNC);
  wire        s_to_func = wr_ssel && (ssel_new[`DAMS_KIND_MSB:`DAMS_KIND_LSB] == dams_pkg::DAMS_KIND_FUNC);

  wire [31:0] first_source_select_nxt  = wr_fsel ? fsel_new : first_source_select_r;
  wire [31:0] second_source_select_nxt = wr_ssel ? ssel_new : second_source_select_r;
  // picking a function view restores its own default scaling
  wire [31:0] first_scale_range_nxt   = f_to_func ? `DAMS_FUNC_RANGE :
                                        wr_frng ? be_merge(first_scale_range_r, i_avs_writedata, i_avs_byteenable) :
                                        first_scale_range_r;
  wire [31:0] first_center_offset_nxt = f_to_func ? `DAMS_OFFSET_RST :
                                        wr_fofs ? be_merge(first_center_offset_r, i_avs_writedata, i_avs_byteenable) :
                                        first_center_offset_r;
  wire [31:0] second_scale_range_nxt  = s_to_func ? `DAMS_FUNC_RANGE :
                                        wr_srng ? be_merge(second_scale_range_r, i_avs_writedata, i_avs_byteenable) :
                                        second_scale_range_r;
  wire [31:0] second_center_offset_nxt = s_to_func ? `DAMS_OFFSET_RST :
                                        wr_sofs ? be_merge(second_center_offset_r, i_avs_writedata, i_avs_byteenable) :
                                        second_center_offset_r;

  wire [31:0] status_word = (32'(second_out_r) << `DAMS_STAT_HI_LSB) | 32'(first_out_r);
  wire [31:0] rd_word =
      (i_avs_address == `DAMS_OFF_FIRST_SEL)  ? first_source_select_r  :
      (i_avs_address == `DAMS_OFF_FIRST_RNG)  ? first_scale_range_r    :
      (i_avs_address == `DAMS_OFF_FIRST_OFS)  ? first_center_offset_r  :
      (i_avs_address == `DAMS_OFF_SECOND_SEL) ? second_source_select_r :
      (i_avs_address == `DAMS_OFF_SECOND_RNG) ? second_scale_range_r   :
      (i_avs_address == `DAMS_OFF_SECOND_OFS) ? second_center_offset_r :
      (i_avs_address == `DAMS_OFF_STATUS)     ? status_word            : 32'h0000_0000;
  wire [31:0] rdata_nxt = (i_avs_read & wait_r) ? rd_word : rdata_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_r                 <= 1'b1;
      rdata_r                <= 32'h0000_0000;
      first_source_select_r  <= `DAMS_SEL_RST;
      first_scale_range_r    <= `DAMS_RANGE_RST;
      first_center_offset_r  <= `DAMS_OFFSET_RST;
      second_source_select_r <= `DAMS_SEL_RST;
      second_scale_range_r   <= `DAMS_RANGE_RST;
      second_center_offset_r <= `DAMS_OFFSET_RST;
    end else begin
      wait_r                 <= wait_nxt;
      rdata_r                <= rdata_nxt;
      first_source_select_r  <= first_source_select_nxt;
      first_scale_range_r    <= first_scale_range_nxt;
      first_center_offset_r  <= first_center_offset_nxt;
      second_source_select_r <= second_source_select_nxt;
      second_scale_range_r   <= second_scale_range_nxt;
      second_center_offset_r <= second_center_offset_nxt;
    end
  end

  // ----------------------------------------------------------------
  // source selection, both outputs served in turn
  // ----------------------------------------------------------------
  dams_pkg::dams_state_e st_r;
  dams_pkg::dams_state_e st_nxt;
  logic                  chan_r;
  logic [31:0]           val_r;
  logic [31:0]           rng_s_r;
  logic [31:0]           ofs_s_r;
  logic                  neg_r;
  logic                  sat_r;
  logic [NW-1:0]         rem_r;
  logic [DAC_W-2:0]      quo_r;
  logic [4:0]            step_r;

  wire [31:0] cur_sel = chan_r ? second_source_select_r : first_source_select_r;
  wire [31:0] cur_rng = chan_r ? second_scale_range_r : first_scale_range_r;
  wire [31:0] cur_ofs = chan_r ? second_center_offset_r : first_center_offset_r;
  wire dams_pkg::dams_kind_e cur_kind = dams_pkg::dams_kind_e'(cur_sel[`DAMS_KIND_MSB:`DAMS_KIND_LSB]);
  wire [3:0]  cur_code = cur_sel[`DAMS_PCODE_MSB:`DAMS_PCODE_LSB];
  wire [4:0]  cur_fidx = cur_sel[`DAMS_FIDX_MSB:`DAMS_FIDX_LSB];
  wire        fidx_ok  = 32'(cur_fidx) < FUNC_N;
  // output functions are seen ahead of their stability timer and polarity
  wire        fstate   = fidx_ok && (cur_sel[`DAMS_FDIR_BIT] ? i_out_func_state[cur_fidx]
                                                             : i_in_func_state[cur_fidx]);
  wire [31:0] preset_v = pick_preset(i_presets, cur_code);
  wire [31:0] link_v   = chan_r ? i_second_link_value : i_first_link_value;
  wire [31:0] func_v   = fstate ? `DAMS_FUNC_ON : 32'h0000_0000;
  wire [31:0] val_mux  = (cur_kind == dams_pkg::DAMS_KIND_PRESET) ? preset_v :
                         (cur_kind == dams_pkg::DAMS_KIND_LINK)   ? link_v   :
                         (cur_kind == dams_pkg::DAMS_KIND_FUNC)   ? func_v   : 32'h0000_0000;

  // ----------------------------------------------------------------
  // scaling: |value - offset| * half span / range, one quotient bit a cycle
  // ----------------------------------------------------------------
  wire signed [32:0] diff   = $signed({val_r[31], val_r}) - $signed({ofs_s_r[31], ofs_s_r});
  wire        [32:0] mag    = diff[32] ? 33'(-diff) : 33'(diff);
  // a range of zero or below cannot scale, so it saturates toward the sign
  wire               sat_c  = ($signed(rng_s_r) <= $signed(32'h0000_0000)) || (mag >= {1'b0, rng_s_r});
  wire  [DAC_W-1:0]  half_c = diff[32] ? HALF_N : HALF_P;
  wire  [NW-1:0]     num_c  = NW'(mag) * NW'(half_c);
  wire  [NW-1:0]     dvs    = NW'(rng_s_r) << step_r;
  wire               ge     = rem_r >= dvs;
  wire  [NW-1:0]     rem_nxt = (st_r == dams_pkg::DAMS_ST_PREP) ? num_c : (ge ? rem_r - dvs : rem_r);
  wire  [DAC_W-2:0]  quo_nxt = (st_r == dams_pkg::DAMS_ST_PREP) ? '0 :
                               (ge ? quo_r | ((DAC_W-1)'(1) << step_r) : quo_r);
  wire  [DAC_W-1:0]  q_ext   = {1'b0, quo_r};
  // the midpoint is the center; full deflection reaches the span ends
  wire  [DAC_W-1:0]  code_c  = neg_r ? (sat_r ? '0 : MID - q_ext)
                                     : (sat_r ? MAXC : MID + q_ext);
  wire               do_store = (st_r == dams_pkg::DAMS_ST_STORE);

  always_comb begin
    case (st_r)
      dams_pkg::DAMS_ST_IDLE:  st_nxt = dams_pkg::DAMS_ST_LOAD;
      dams_pkg::DAMS_ST_LOAD:  st_nxt = dams_pkg::DAMS_ST_PREP;
      dams_pkg::DAMS_ST_PREP:  st_nxt = dams_pkg::DAMS_ST_DIV;
      dams_pkg::DAMS_ST_DIV:   st_nxt = (step_r == 5'h00) ? dams_pkg::DAMS_ST_STORE : dams_pkg::DAMS_ST_DIV;
      dams_pkg::DAMS_ST_STORE: st_nxt = dams_pkg::DAMS_ST_LOAD;
      default:                 st_nxt = dams_pkg::DAMS_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r   <= dams_pkg::DAMS_ST_IDLE;
      chan_r <= 1'b0;
      step_r <= 5'h00;
      rem_r  <= '0;
      quo_r  <= '0;
    end else begin
      st_r   <= st_nxt;
      chan_r <= do_store ? ~chan_r : chan_r;
      step_r <= (st_r == dams_pkg::DAMS_ST_PREP) ? 5'(DAC_W-2) : (step_r - 5'h01);
      rem_r  <= rem_nxt;
      quo_r  <= quo_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      val_r   <= 32'h0000_0000;
      rng_s_r <= `DAMS_RANGE_RST;
      ofs_s_r <= `DAMS_OFFSET_RST;
      neg_r   <= 1'b0;
      sat_r   <= 1'b0;
    end else if (st_r == dams_pkg::DAMS_ST_LOAD) begin
      val_r   <= val_mux;
      rng_s_r <= cur_rng;
      ofs_s_r <= cur_ofs;
    end else if (st_r == dams_pkg::DAMS_ST_PREP) begin
      neg_r   <= diff[32];
      sat_r   <= sat_c;
    end
  end

  // outputs start at the midpoint until the first conversion lands
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      first_out_r  <= MID;
      second_out_r <= MID;
    end else begin
      first_out_r  <= (do_store && !chan_r) ? code_c : first_out_r;
      second_out_r <= (do_store && chan_r) ? code_c : second_out_r;
    end
  end

  assign o_avs_waitrequest   = wait_r;
  assign o_avs_readdata      = rdata_r;
  assign o_first_analog_out  = first_out_r;
  assign o_second_analog_out = second_out_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic wrote_any_r;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wrote_any_r <= 1'b0;
    end else begin
      wrote_any_r <= wrote_any_r | commit;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_RESET_DEFAULTS: assert property (!wrote_any_r |-> first_source_select_r == `DAMS_SEL_RST
      && second_scale_range_r == `DAMS_RANGE_RST && first_center_offset_r == `DAMS_OFFSET_RST)
    else $error("register left its reset default without a write");
  AST_RANGE_DEFAULT: assert property (!wrote_any_r |-> first_scale_range_r == 32'h0000_2710)
    else $error("range default is not 10.000");
  AST_FUNC_DEFAULT: assert property (f_to_func |=> first_scale_range_r == `DAMS_FUNC_RANGE
      && first_center_offset_r == 32'h0000_0000)
    else $error("function select did not load unit range and zero center");
  AST_PRESET_PICK: assert property (st_r == dams_pkg::DAMS_ST_LOAD
      && cur_kind == dams_pkg::DAMS_KIND_PRESET && cur_code == 4'h0 |=> val_r == $past(i_presets.act_vel))
    else $error("preset 0 did not pick actual velocity");
  AST_LINK_PICK: assert property (st_r == dams_pkg::DAMS_ST_LOAD && !chan_r
      && cur_kind == dams_pkg::DAMS_KIND_LINK |=> val_r == $past(i_first_link_value))
    else $error("link readout not routed to the first output");
  AST_FUNC_LEVEL: assert property (st_r == dams_pkg::DAMS_ST_LOAD
      && cur_kind == dams_pkg::DAMS_KIND_FUNC |=> val_r == ($past(fstate) ? 32'h0000_03e8 : 32'h0000_0000))
    else $error("function state value wrong");
  AST_MIDPOINT: assert property (do_store && !chan_r && !sat_r && quo_r == '0 && !neg_r
      |=> o_first_analog_out == MID)
    else $error("zero deflection missed the midpoint");
  AST_CLAMP_HIGH: assert property (st_r == dams_pkg::DAMS_ST_PREP && !diff[32] && sat_c
      |-> ##12 do_store ##1 ((chan_r ? o_first_analog_out : o_second_analog_out) == MAXC))
    else $error("overrange did not clamp to full scale");
  AST_CLAMP_LOW: assert property (do_store && neg_r && sat_r |=>
      (chan_r ? o_first_analog_out : o_second_analog_out) == '0)
    else $error("underrange did not clamp to zero");
  AST_CHAN_ROUTE: assert property ($changed(o_first_analog_out) |-> $past(do_store && !chan_r))
    else $error("first output changed outside its own update");
  AST_DIV_BOUND: assert property (st_r == dams_pkg::DAMS_ST_PREP |-> ##[1:16] do_store)
    else $error("conversion did not finish in time");

  COV_FUNC_SEL:  cover property (f_to_func ##[1:40] (do_store && !chan_r));
  COV_SAT_HIGH:  cover property (do_store && sat_r && !neg_r);
  COV_LINK:      cover property (do_store && cur_kind == dams_pkg::DAMS_KIND_LINK);
  COV_READ_STAT: cover property (i_avs_read && !wait_r && i_avs_address == `DAMS_OFF_STATUS);
endmodule // dams_top
`default_nettype wire
